// ==== core/dbo_key_guard.sv ====
// Unlock sequencer that holds the buffer op amp select value
`timescale 1ns/1ps
`default_nettype none
module dbo_key_guard
  import dbo_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Write strobes from the bus slave
  dbo_wr_if.guard wr
);
  dbo_key_state_t state_r; // Sequencer position
  dbo_key_state_t state_nxt;
  logic [7:0] stage_r; // Value waiting for the second key
  logic [7:0] stage_nxt;
  logic [7:0] cfg_r; // Committed select value
  logic [7:0] cfg_nxt;
  logic key0_ok; // First key code matches
  logic key1_ok; // Second key code matches

  assign key0_ok = (wr.wdata[15:0] == DBO_KEY_FIRST_CODE);
  assign key1_ok = (wr.wdata[15:0] == DBO_KEY_SECOND_CODE);
  assign wr.cfg = cfg_r;

  // ------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------
  // Any unlock or select write out of order drops back to idle, except a matching first key,
  // which re-arms; a stray write can never commit a half-framed value
  always_comb
  begin
    state_nxt = state_r;
    stage_nxt = stage_r;
    cfg_nxt = cfg_r;
    case (state_r)
      DBO_KS_IDLE:
      begin
        if (wr.key0_we && key0_ok) // RL9
          state_nxt = DBO_KS_ARMED;
      end
      DBO_KS_ARMED:
      begin
        if (wr.cfg_we)
        begin
          // Reserved upper bits are never stored
          stage_nxt = wr.wdata[7:0] & DBO_SELECT_FUNC_MASK; // RL9
          state_nxt = DBO_KS_STAGED;
        end
        else if (wr.key0_we)
          state_nxt = key0_ok ? DBO_KS_ARMED : DBO_KS_IDLE;
        else if (wr.key1_we)
          state_nxt = DBO_KS_IDLE; // RL10
      end
      DBO_KS_STAGED:
      begin
        if (wr.key1_we)
        begin
          if (key1_ok)
            cfg_nxt = stage_r; // RL9
          state_nxt = DBO_KS_IDLE; // RL10
        end
        else if (wr.key0_we)
          state_nxt = key0_ok ? DBO_KS_ARMED : DBO_KS_IDLE;
        else if (wr.cfg_we)
          state_nxt = DBO_KS_IDLE; // RL10
      end
      default:
        state_nxt = DBO_KS_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer registers
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= DBO_KS_IDLE;
      stage_r <= DBO_SELECT_RESET;
      cfg_r <= DBO_SELECT_RESET; // RL7
    end
    else
    begin
      state_r <= state_nxt;
      stage_r <= stage_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_framed_commit: assert property ( // RL9
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_r == DBO_KS_STAGED && wr.key1_we && key1_ok) |=> (cfg_r == $past(stage_r)))
    else $error("framed write not committed");
  chk_unframed_hold: assert property ( // RL10
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !(state_r == DBO_KS_STAGED && wr.key1_we && key1_ok) |=> $stable(cfg_r))
    else $error("select changed without framing");
endmodule
`default_nettype wire

// ==== core/dbo_opamp_cfg.sv ====
// AXI4-Lite register bank for the key protected buffer op amp select
//
// How it works
// RL1: Op amp mode bypasses converter, buffer standalone
// RL2: Bit 0: in_0 plus, in_1 minus, out_0
// RL3: Bit 1: in_2 plus, in_3 minus, out_1
// RL4: Bit 2: in_4 plus, in_5 minus, out_2
// RL5: Bit 3: in_8 plus, in_9 minus, out_3
// RL6: Software powers down converter in op amp mode
// RL7: Cleared bit is normal; resets to zero
// RL8: Software writes zero to upper four bits
// RL9: First key, select value, second key
// RL10: Unframed select writes are ignored
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dbo_opamp_cfg
  import dbo_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // AXI4-Lite write address and data
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // AXI4-Lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // AXI4-Lite read
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [31:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // Analog switch controls
  output logic [DBO_NUM_CH-1:0] o_buf_opamp_en,
  output logic [DBO_NUM_CH-1:0] o_conv_path_en,
  output logic [DBO_NUM_AIN-1:0] o_opamp_pos_sw,
  output logic [DBO_NUM_AIN-1:0] o_opamp_neg_sw
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  dbo_wr_if wr (); // Strobes to the sequencer
  logic aw_hold_r; // Write address captured
  logic aw_hold_nxt;
  logic [31:0] aw_addr_r;
  logic [31:0] aw_addr_nxt;
  logic w_hold_r; // Write data captured
  logic w_hold_nxt;
  logic [31:0] w_data_r; // Data with unstrobed lanes zeroed
  logic [31:0] w_data_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic do_wr; // Both halves held, response slot free
  logic wr_hit; // Write lands on a mapped register
  logic [DBO_NUM_CH-1:0] opamp_r; // Registered switch controls
  logic [DBO_NUM_AIN-1:0] pos_r;
  logic [DBO_NUM_AIN-1:0] neg_r;
  logic [DBO_NUM_AIN-1:0] pos_nxt;
  logic [DBO_NUM_AIN-1:0] neg_nxt;
  logic [DBO_NUM_AIN-1:0] pos_ch [DBO_NUM_CH]; // Per channel contribution
  logic [DBO_NUM_AIN-1:0] neg_ch [DBO_NUM_CH];

  // ------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------
  // Address and data are taken in either order; no new ones are taken
  // until the response has gone, so one write is under way at a time
  assign o_s_axi_awready = !aw_hold_r && !bvalid_r;
  assign o_s_axi_wready = !w_hold_r && !bvalid_r;
  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_hit = (aw_addr_r == DBO_ADDR_UNLOCK_FIRST) ||
                  (aw_addr_r == DBO_ADDR_OPAMP_SELECT) ||
                  (aw_addr_r == DBO_ADDR_UNLOCK_SECOND);
  assign wr.key0_we = do_wr && (aw_addr_r == DBO_ADDR_UNLOCK_FIRST);
  assign wr.cfg_we = do_wr && (aw_addr_r == DBO_ADDR_OPAMP_SELECT);
  assign wr.key1_we = do_wr && (aw_addr_r == DBO_ADDR_UNLOCK_SECOND);
  assign wr.wdata = w_data_r;

  // Next values of the write channel state
  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt = w_hold_r;
    w_data_nxt = w_data_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (i_s_axi_awvalid && o_s_axi_awready)
    begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready)
    begin
      w_hold_nxt = 1'b1;
      for (int b = 0; b < 4; b++)
        w_data_nxt[8*b +: 8] = i_s_axi_wstrb[b] ? i_s_axi_wdata[8*b +: 8] : 8'h00;
    end
    if (do_wr)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      // Unmapped addresses answer with a slave error
      bresp_nxt = wr_hit ? DBO_RESP_OKAY : DBO_RESP_SLVERR;
    end
    else if (bvalid_r && i_s_axi_bready)
      bvalid_nxt = 1'b0;
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  assign o_s_axi_arready = !rvalid_r;

  // Unlock registers are write only and read as zero
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = DBO_RESP_OKAY;
      if (i_s_axi_araddr == DBO_ADDR_OPAMP_SELECT)
        rdata_nxt = {24'h00_0000, wr.cfg};
      else if ((i_s_axi_araddr != DBO_ADDR_UNLOCK_FIRST) &&
               (i_s_axi_araddr != DBO_ADDR_UNLOCK_SECOND))
        rresp_nxt = DBO_RESP_SLVERR;
    end
    else if (rvalid_r && i_s_axi_rready)
      rvalid_nxt = 1'b0;
  end

  // Bus registers
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      bvalid_r <= 1'b0;
      bresp_r <= DBO_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= DBO_RESP_OKAY;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;
  assign o_s_axi_rresp = rresp_r;

  // ------------------------------------------------------------
  // Unlock sequencer
  // ------------------------------------------------------------
  dbo_key_guard u_guard (
    .i_core_clk (i_core_clk),
    .i_rst_n (i_rst_n),
    .wr (wr.guard)
  );

  // ------------------------------------------------------------
  // Analog switch decode
  // ------------------------------------------------------------
  // Each buffer in op amp mode closes its two input switches
  for (genvar ch = 0; ch < DBO_NUM_CH; ch++)
  begin : g_ch
    always_comb
    begin
      pos_ch[ch] = '0;
      neg_ch[ch] = '0;
      pos_ch[ch][DBO_POS_PIN[ch]] = wr.cfg[ch]; // RL2 RL3 RL4 RL5
      neg_ch[ch][DBO_NEG_PIN[ch]] = wr.cfg[ch]; // RL2 RL3 RL4 RL5
    end
  end

  // Merge channels; pin sets are disjoint so OR is safe
  always_comb
  begin
    pos_nxt = '0;
    neg_nxt = '0;
    for (int c = 0; c < DBO_NUM_CH; c++)
    begin
      pos_nxt = pos_nxt | pos_ch[c];
      neg_nxt = neg_nxt | neg_ch[c];
    end
  end

  // All switch outputs move together, one cycle after a commit
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      opamp_r <= '0; // RL7
      pos_r <= '0;
      neg_r <= '0;
    end
    else
    begin
      opamp_r <= wr.cfg[DBO_NUM_CH-1:0]; // RL1
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
    end
  end

  assign o_buf_opamp_en = opamp_r;
  assign o_conv_path_en = ~opamp_r; // RL1 RL7
  assign o_opamp_pos_sw = pos_r;
  assign o_opamp_neg_sw = neg_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_conv_bypass: assert property (##1 (o_conv_path_en == ~$past(wr.cfg[3:0]))) // RL1
    else $error("converter path open in op amp mode");
  chk_ch0_pins: assert property (o_buf_opamp_en[0] == (o_opamp_pos_sw[0] && o_opamp_neg_sw[1])) // RL2
    else $error("channel 0 pin routing wrong");
  chk_ch1_pins: assert property (o_buf_opamp_en[1] == (o_opamp_pos_sw[2] && o_opamp_neg_sw[3])) // RL3
    else $error("channel 1 pin routing wrong");
  chk_ch2_pins: assert property (o_buf_opamp_en[2] == (o_opamp_pos_sw[4] && o_opamp_neg_sw[5])) // RL4
    else $error("channel 2 pin routing wrong");
  chk_ch3_pins: assert property (o_buf_opamp_en[3] == (o_opamp_pos_sw[8] && o_opamp_neg_sw[9])) // RL5
    else $error("channel 3 pin routing wrong");
  chk_mode_follows: assert property (##1 o_buf_opamp_en == $past(wr.cfg[3:0])) // RL7
    else $error("buffer mode does not follow select value");
  chk_select_readback: assert property ( // RL7
    (i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == DBO_ADDR_OPAMP_SELECT)
    |=> (o_s_axi_rvalid && o_s_axi_rdata[31:4] == 28'h0 && o_s_axi_rdata[3:0] == $past(wr.cfg[3:0])))
    else $error("select readback wrong");
  chk_write_answer: assert property ( // RL9
    do_wr |=> (o_s_axi_bvalid &&
               o_s_axi_bresp == ($past(wr_hit) ? DBO_RESP_OKAY : DBO_RESP_SLVERR)))
    else $error("write not answered");
endmodule
`default_nettype wire

// ==== core/dbo_pkg.sv ====
// Constants and types for the buffer op amp configuration block
`default_nettype none
package dbo_pkg;
  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [31:0] DBO_ADDR_UNLOCK_FIRST = 32'hffff0650;
  localparam logic [31:0] DBO_ADDR_OPAMP_SELECT = 32'hffff0654;
  localparam logic [31:0] DBO_ADDR_UNLOCK_SECOND = 32'hffff0658;
  // ------------------------------------------------------------
  // Key codes, reset values, field layout
  // ------------------------------------------------------------
  localparam logic [15:0] DBO_KEY_FIRST_CODE = 16'h009a;
  localparam logic [15:0] DBO_KEY_SECOND_CODE = 16'h000c;
  localparam logic [15:0] DBO_KEY_RESET = 16'h0000;
  localparam logic [7:0] DBO_SELECT_RESET = 8'h00;
  localparam logic [7:0] DBO_SELECT_FUNC_MASK = 8'h0f;
  localparam int DBO_NUM_CH = 4;
  localparam int DBO_NUM_AIN = 10;
  // Analog input pin feeding each buffer's positive and negative input
  localparam logic [3:0] DBO_POS_PIN [0:3] = '{4'h0, 4'h2, 4'h4, 4'h8};
  localparam logic [3:0] DBO_NEG_PIN [0:3] = '{4'h1, 4'h3, 4'h5, 4'h9};
  // ------------------------------------------------------------
  // Bus responses
  // ------------------------------------------------------------
  localparam logic [1:0] DBO_RESP_OKAY = 2'b00;
  localparam logic [1:0] DBO_RESP_SLVERR = 2'b10;
  // Unlock sequencer states
  typedef enum logic [2:0] {
    DBO_KS_IDLE = 3'b001,
    DBO_KS_ARMED = 3'b010,
    DBO_KS_STAGED = 3'b100
  } dbo_key_state_t;
endpackage
`default_nettype wire

// ==== core/dbo_wr_if.sv ====
// Register write strobes between the bus slave and the unlock sequencer
`timescale 1ns/1ps
`default_nettype none
interface dbo_wr_if;
  logic key0_we; // Write to first unlock register
  logic cfg_we; // Write to select register
  logic key1_we; // Write to second unlock register
  logic [31:0] wdata; // Lane-masked write data
  logic [7:0] cfg; // Committed select value
  modport bus (output key0_we, output cfg_we, output key1_we, output wdata, input cfg);
  modport guard (input key0_we, input cfg_we, input key1_we, input wdata, output cfg);
endinterface
`default_nettype wire

// ==== dv/dbo_tb_top.sv ====
// Self-checking bench for the key protected buffer op amp select bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dbo_pkg::*;
;
  // ----------------------------------------
  // Clock, reset, bus drive and observation
  // ----------------------------------------
  logic clk;
  logic rst_n;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] opamp_en, conv_en;
  logic [9:0] pos_sw, neg_sw;
  int err_count;
  int n_compared;
  // Positive input pin of each buffer; the negative one is the next pin
  int pin_p [4] = '{0, 2, 4, 8};
  // ----------------------------------------
  // Device under test
  // ----------------------------------------
  dbo_opamp_cfg dut (
    .i_core_clk(clk), .i_rst_n(rst_n),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_buf_opamp_en(opamp_en),
    .o_conv_path_en(conv_en), .o_opamp_pos_sw(pos_sw), .o_opamp_neg_sw(neg_sw)
  );
  // Free running core clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Bus tasks; ready is sampled at the falling edge, where it is settled
  // ----------------------------------------
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    int n;
    hb = 1'b0;
    n = 0;
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    while (!hb && n < 100)
    begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      n++;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // Let an edge pass so the next call never re-drives bready in this step
    @(posedge clk);
    cmp({31'h0, hb}, 32'h1);
    cmp({30'h0, r}, {30'h0, er});
  endtask
  task automatic axi_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    hr = 1'b0;
    n = 0;
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    while (!hr && n < 100)
    begin
      @(negedge clk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      n++;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    // Let an edge pass so the next call never re-drives rready in this step
    @(posedge clk);
    cmp({31'h0, hr}, 32'h1);
    cmp(d, ed);
    cmp({30'h0, r}, {30'h0, er});
  endtask
  // Framed select write: first key, value, second key
  task automatic unlock(input logic [31:0] v);
    axi_write(DBO_ADDR_UNLOCK_FIRST, 32'h9a, DBO_RESP_OKAY);
    axi_write(DBO_ADDR_OPAMP_SELECT, v, DBO_RESP_OKAY);
    axi_write(DBO_ADDR_UNLOCK_SECOND, 32'h0c, DBO_RESP_OKAY);
  endtask
  // Analog controls against the expected channel set; waits past the commit
  task automatic chk_out(input logic [3:0] s);
    logic [9:0] p, q;
    p = '0;
    q = '0;
    for (int c = 0; c < 4; c++)
    begin
      if (s[c])
      begin
        p[pin_p[c]] = 1'b1;
        q[pin_p[c] + 1] = 1'b1;
      end
    end
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp(32'(opamp_en), 32'(s));
    cmp(32'(conv_en), {28'h0, ~s});
    cmp(32'(pos_sw), 32'(p));
    cmp(32'(neg_sw), 32'(q));
    @(posedge clk);
  endtask
  // One channel at a time: commit, read back, check the switches
  task automatic step(input logic [3:0] s);
    unlock({28'h0, s});
    axi_read(DBO_ADDR_OPAMP_SELECT, {28'h0, s}, DBO_RESP_OKAY);
    chk_out(s);
  endtask
  // ----------------------------------------
  // Watchdog: the whole run needs well under 5000 cycles
  // ----------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    err_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = '0; wdata = '0; araddr = '0; wstrb = 4'hf;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axi_read(DBO_ADDR_OPAMP_SELECT, 32'h0, DBO_RESP_OKAY);
    chk_out(4'h0);
    // Unframed write must leave every buffer in normal duty
    axi_write(DBO_ADDR_OPAMP_SELECT, 32'h5, DBO_RESP_OKAY);
    axi_read(DBO_ADDR_OPAMP_SELECT, 32'h0, DBO_RESP_OKAY);
    chk_out(4'h0);
    step(4'h1);
    step(4'h2);
    step(4'h4);
    step(4'h8);
    // Upper bits are dropped, all four buffers switch over
    unlock(32'hff);
    axi_read(DBO_ADDR_OPAMP_SELECT, 32'h0f, DBO_RESP_OKAY);
    chk_out(4'hf);
    // Wrong second key discards the staged value
    axi_write(DBO_ADDR_UNLOCK_FIRST, 32'h9a, DBO_RESP_OKAY);
    axi_write(DBO_ADDR_OPAMP_SELECT, 32'h0, DBO_RESP_OKAY);
    axi_write(DBO_ADDR_UNLOCK_SECOND, 32'h0d, DBO_RESP_OKAY);
    // Missing first key: value then second key alone
    axi_write(DBO_ADDR_OPAMP_SELECT, 32'h0, DBO_RESP_OKAY);
    axi_write(DBO_ADDR_UNLOCK_SECOND, 32'h0c, DBO_RESP_OKAY);
    axi_read(DBO_ADDR_OPAMP_SELECT, 32'h0f, DBO_RESP_OKAY);
    chk_out(4'hf);
    // Unmapped write inside a sequence does not break it
    axi_write(DBO_ADDR_UNLOCK_FIRST, 32'h9a, DBO_RESP_OKAY);
    axi_write(32'hffff0660, 32'h1, DBO_RESP_SLVERR);
    axi_write(DBO_ADDR_OPAMP_SELECT, 32'h3, DBO_RESP_OKAY);
    axi_write(DBO_ADDR_UNLOCK_SECOND, 32'h0c, DBO_RESP_OKAY);
    axi_read(DBO_ADDR_OPAMP_SELECT, 32'h3, DBO_RESP_OKAY);
    chk_out(4'h3);
    // Write-only keys read as zero, unmapped read is refused
    axi_read(DBO_ADDR_UNLOCK_FIRST, 32'h0, DBO_RESP_OKAY);
    axi_read(DBO_ADDR_UNLOCK_SECOND, 32'h0, DBO_RESP_OKAY);
    axi_read(32'hffff0660, 32'h0, DBO_RESP_SLVERR);
    // Unstrobed upper lanes count as zero, so a lane-masked first key still arms
    wstrb <= 4'h1;
    axi_write(DBO_ADDR_UNLOCK_FIRST, 32'h0000_ff9a, DBO_RESP_OKAY);
    wstrb <= 4'hf;
    axi_write(DBO_ADDR_OPAMP_SELECT, 32'h5, DBO_RESP_OKAY);
    axi_write(DBO_ADDR_UNLOCK_SECOND, 32'h0c, DBO_RESP_OKAY);
    axi_read(DBO_ADDR_OPAMP_SELECT, 32'h5, DBO_RESP_OKAY);
    // Clearing returns buffers to normal duty
    unlock(32'h0);
    chk_out(4'h0);
    // Reset in mid-run brings the select back to zero
    unlock(32'h6);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axi_read(DBO_ADDR_OPAMP_SELECT, 32'h0, DBO_RESP_OKAY);
    chk_out(4'h0);
    finish_test();
  end
endmodule
`default_nettype wire
